/* common/ratio_pkg.sv */
`default_nettype none
package ratio_pkg;
   // multiplier expressed in half steps (value x2)
   localparam int CFG_W = 6;
   localparam int MULT_W = 7;
   localparam logic [5:0] CFG_10X5 = 6'h22;
   localparam logic [5:0] CFG_11X = 6'h26;
   localparam logic [5:0] CFG_11X5 = 6'h00;
   localparam logic [5:0] CFG_12X = 6'h2e;
   localparam logic [5:0] CFG_12X5 = 6'h3e;
   localparam logic [5:0] CFG_13X = 6'h16;
   localparam logic [5:0] CFG_13X5 = 6'h38;
   localparam logic [5:0] CFG_14X = 6'h32;
   localparam logic [5:0] CFG_15X = 6'h06;
   localparam logic [5:0] CFG_16X = 6'h36;
   localparam logic [5:0] CFG_17X = 6'h02;
   localparam logic [5:0] CFG_18X = 6'h0a;
   localparam logic [5:0] CFG_20X = 6'h0e;
   localparam logic [5:0] CFG_21X = 6'h12;
   localparam logic [5:0] CFG_24X = 6'h1a;
   localparam logic [5:0] CFG_28X = 6'h3a;
   localparam logic [5:0] CFG_BYPASS = 6'h0c;
   localparam logic [5:0] CFG_OFF = 6'h3c;
   localparam logic [6:0] VCO_MULT_1X = 7'h02;
   localparam logic [6:0] MULT_NONE = 7'h00;
   // bypass core runs at the bus clock, reported as 1x
   localparam logic [7:0] CORE_MULT_1X = 8'h04;
   localparam logic [7:0] CORE_NONE = 8'h00;
   localparam logic [1:0] DFS_NONE = 2'h0;
   localparam logic [1:0] DFS_HALF = 2'h1;
   localparam logic [1:0] DFS_QUARTER = 2'h2;
   // core multiplier x4 output width
   localparam int CORE_W = 8;
endpackage : ratio_pkg
`default_nettype wire

/* hdl/ratio_lut.sv */
`default_nettype none
module ratio_lut (
   // clock
   input wire logic clk,
   // lookup
   input wire logic [5:0] code,
   output logic [6:0] mult_x2,
   output logic known
);
   typedef struct packed {
      logic [6:0] mult;
      logic known;
   } lut_t;

   lut_t lut_reg;
   lut_t lut_next;

   always_comb begin
      lut_next.known = 1'b1;
      case (code)
         ratio_pkg::CFG_10X5: lut_next.mult = 7'h15;
         ratio_pkg::CFG_11X: lut_next.mult = 7'h16;
         ratio_pkg::CFG_11X5: lut_next.mult = 7'h17;
         ratio_pkg::CFG_12X: lut_next.mult = 7'h18;
         ratio_pkg::CFG_12X5: lut_next.mult = 7'h19;
         ratio_pkg::CFG_13X: lut_next.mult = 7'h1a;
         ratio_pkg::CFG_13X5: lut_next.mult = 7'h1b;
         ratio_pkg::CFG_14X: lut_next.mult = 7'h1c;
         ratio_pkg::CFG_15X: lut_next.mult = 7'h1e;
         ratio_pkg::CFG_16X: lut_next.mult = 7'h20;
         ratio_pkg::CFG_17X: lut_next.mult = 7'h22;
         ratio_pkg::CFG_18X: lut_next.mult = 7'h24;
         ratio_pkg::CFG_20X: lut_next.mult = 7'h28;
         ratio_pkg::CFG_21X: lut_next.mult = 7'h2a;
         ratio_pkg::CFG_24X: lut_next.mult = 7'h30;
         ratio_pkg::CFG_28X: lut_next.mult = 7'h38;
         default: begin
            lut_next.mult = ratio_pkg::MULT_NONE;
            lut_next.known = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      lut_reg <= lut_next;
   end

   assign mult_x2 = lut_reg.mult;
   assign known = lut_reg.known;
endmodule : ratio_lut
`default_nettype wire

/* hdl/pll_ratio_strap_decoder.sv */
// Contract
// - codes 100010,100110,000000,101110 give 10.5x,11x,11.5x,12x with VCO 1x.
// - codes 111110,010110,111000,110010 give 12.5x,13x,13.5x,14x with VCO 1x.
// - codes 000110,110110,000010,001010 give 15x,16x,17x,18x with VCO 1x.
// - codes 001110,010010,011010,111010 give 20x,21x,24x,28x with VCO 1x.
// - code 001100 bypasses the PLL and clocks the core from the bus clock.
// - code 111100 turns the PLL off and stops all internal clocking.
// - in bypass the bus runs at half the bus clock, the core at full rate.
// - decoded multipliers apply only with frequency switching disabled; the code also applies them unchanged with select value 3.
// - core and VCO frequency follow the six configuration inputs as sampled once after reset release.
// - frequency switching halves or quarters the decoded multiplier.
`default_nettype none
module pll_ratio_strap_decoder (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // straps and bus clock qualifier
   input wire logic [5:0] RATIO_CFG,
   input wire logic BYPASS_PHASE_QUALIFIER,
   // frequency switching select: 0 off, 1 half, 2 quarter
   input wire logic [1:0] DYNAMIC_FREQ_SWITCHING,
   // decoded results, core multiplier in quarter steps (x4), VCO multiplier in half steps (x2)
   output logic [7:0] CORE_MULT_X4,
   output logic [6:0] VCO_MULT_X2,
   output logic PLL_ENABLE,
   output logic PLL_BYPASS,
   output logic CORE_CLOCK_ENABLE,
   output logic BUS_CLOCK_ENABLE,
   output logic RESERVED_CODE,
   output logic CFG_VALID
);
   typedef enum logic [3:0] {
      ST_RESET = 4'h1,
      ST_CAPTURE = 4'h2,
      ST_DECODE = 4'h4,
      ST_RUN = 4'h8
   } state_t;

   typedef struct packed {
      state_t st;
      logic [5:0] cfg;
      logic [7:0] core;
      logic [6:0] vco;
      logic pll_en;
      logic bypass;
      logic core_en;
      logic bus_en;
      logic reserved;
      logic valid;
   } regs_t;

   regs_t state_reg;
   regs_t state_next;
   logic [6:0] lut_mult;
   logic lut_known;

   // decode of the latched code, registered
   ratio_lut u_lut (
      .clk(MCLK),
      .code(state_reg.cfg),
      .mult_x2(lut_mult),
      .known(lut_known)
   );

   function automatic logic [7:0] apply_dfs(input logic [6:0] m2, input logic [1:0] sel);
      logic [7:0] m4;
      m4 = {m2, 1'h0};
      case (sel)
         ratio_pkg::DFS_HALF: apply_dfs = {1'h0, m4[7:1]};
         ratio_pkg::DFS_QUARTER: apply_dfs = {2'h0, m4[7:2]};
         default: apply_dfs = m4;
      endcase
   endfunction : apply_dfs

   always_comb begin
      state_next = state_reg;
      case (state_reg.st)
         ST_RESET: state_next.st = ST_CAPTURE;
         // straps sampled once after reset release; held stable by the board
         ST_CAPTURE: begin
            state_next.cfg = RATIO_CFG;
            state_next.st = ST_DECODE;
         end
         // wait one cycle for the registered lookup
         ST_DECODE: state_next.st = ST_RUN;
         ST_RUN: begin
            state_next.valid = 1'b1;
            state_next.vco = ratio_pkg::MULT_NONE;
            state_next.core = ratio_pkg::CORE_NONE;
            state_next.pll_en = 1'b0;
            state_next.bypass = 1'b0;
            state_next.core_en = 1'b0;
            state_next.bus_en = 1'b0;
            state_next.reserved = 1'b0;
            if (state_reg.cfg == ratio_pkg::CFG_BYPASS) begin
               state_next.bypass = 1'b1;
               state_next.core_en = 1'b1;
               state_next.core = ratio_pkg::CORE_MULT_1X;
               state_next.bus_en = BYPASS_PHASE_QUALIFIER;
            end else if (state_reg.cfg == ratio_pkg::CFG_OFF) begin
               state_next.core_en = 1'b0;
            end else if (lut_known) begin
               state_next.pll_en = 1'b1;
               state_next.core_en = 1'b1;
               state_next.bus_en = 1'b1;
               state_next.vco = ratio_pkg::VCO_MULT_1X;
               state_next.core = apply_dfs(lut_mult, DYNAMIC_FREQ_SWITCHING);
            end else begin
               // reserved codes leave all clocks stopped
               state_next.reserved = 1'b1;
            end
         end
         default: state_next.st = ST_RESET;
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_reg <= '{st: ST_RESET, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign CORE_MULT_X4 = state_reg.core;
   assign VCO_MULT_X2 = state_reg.vco;
   assign PLL_ENABLE = state_reg.pll_en;
   assign PLL_BYPASS = state_reg.bypass;
   assign CORE_CLOCK_ENABLE = state_reg.core_en;
   assign BUS_CLOCK_ENABLE = state_reg.bus_en;
   assign RESERVED_CODE = state_reg.reserved;
   assign CFG_VALID = state_reg.valid;
endmodule : pll_ratio_strap_decoder
`default_nettype wire

/* verification/ratio_chk_sva.sv */
`default_nettype none
module ratio_chk (
   input wire logic MCLK, RST, BYPASS_PHASE_QUALIFIER,
   input wire logic [1:0] DYNAMIC_FREQ_SWITCHING,
   input wire logic [7:0] CORE_MULT_X4,
   input wire logic [6:0] VCO_MULT_X2,
   input wire logic PLL_ENABLE, PLL_BYPASS, CORE_CLOCK_ENABLE, BUS_CLOCK_ENABLE, RESERVED_CODE, CFG_VALID
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   property p_vld; $rose(CFG_VALID) |-> !$past(RST, 3); endproperty
   a_vld: assert property (p_vld) else $error("early valid");
   property p_vco; PLL_ENABLE |-> VCO_MULT_X2 == 7'h02 && CORE_CLOCK_ENABLE && BUS_CLOCK_ENABLE; endproperty
   a_vco: assert property (p_vco) else $error("bad vco");
   property p_byp; PLL_BYPASS |-> !PLL_ENABLE && CORE_CLOCK_ENABLE && CORE_MULT_X4 == 8'h04; endproperty
   a_byp: assert property (p_byp) else $error("bad bypass");
   property p_bus; PLL_BYPASS && $past(PLL_BYPASS) |-> BUS_CLOCK_ENABLE == $past(BYPASS_PHASE_QUALIFIER); endproperty
   a_bus: assert property (p_bus) else $error("bad bus");
   property p_off; CFG_VALID && !PLL_ENABLE && !PLL_BYPASS |-> !CORE_CLOCK_ENABLE && !BUS_CLOCK_ENABLE; endproperty
   a_off: assert property (p_off) else $error("clock on");
   property p_rsv; RESERVED_CODE |-> CORE_MULT_X4 == 8'h00 && !PLL_ENABLE && !PLL_BYPASS; endproperty
   a_rsv: assert property (p_rsv) else $error("bad reserved");
   property p_dfs; $past(PLL_ENABLE) && $past(DYNAMIC_FREQ_SWITCHING, 2) == 2'h0
      && $past(DYNAMIC_FREQ_SWITCHING) == 2'h1 |-> CORE_MULT_X4 == $past(CORE_MULT_X4) >> 1; endproperty
   a_dfs: assert property (p_dfs) else $error("bad half");
   property p_hld; CFG_VALID && $past(CFG_VALID) |-> $stable(PLL_ENABLE) && $stable(RESERVED_CODE); endproperty
   a_hld: assert property (p_hld) else $error("moved");
endmodule : ratio_chk
bind pll_ratio_strap_decoder ratio_chk chk (.MCLK(MCLK), .RST(RST), .BYPASS_PHASE_QUALIFIER(BYPASS_PHASE_QUALIFIER),
   .DYNAMIC_FREQ_SWITCHING(DYNAMIC_FREQ_SWITCHING), .CORE_MULT_X4(CORE_MULT_X4), .VCO_MULT_X2(VCO_MULT_X2),
   .PLL_ENABLE(PLL_ENABLE), .PLL_BYPASS(PLL_BYPASS), .CORE_CLOCK_ENABLE(CORE_CLOCK_ENABLE),
   .BUS_CLOCK_ENABLE(BUS_CLOCK_ENABLE), .RESERVED_CODE(RESERVED_CODE), .CFG_VALID(CFG_VALID));
`default_nettype wire

/* verification/strap_board.sv */
`default_nettype none
module strap_board (
   input wire logic clk,
   input wire logic [5:0] code,
   output logic [5:0] cfg,
   output var logic qual = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // bit 0 is the low bit here, low in every legal code
   // no code below 5x exists here, so no acknowledge delay
   assign cfg = code;
   always @(negedge clk) qual <= ~qual;
endmodule : strap_board
`default_nettype wire

/* verification/pll_ratio_strap_decoder_tb.sv */
`default_nettype none
module pll_ratio_strap_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic [5:0] code = 6'h00;
   logic [1:0] dynamic_freq_switching = 2'h0;
   logic [5:0] cfg;
   logic qual, pen, byp, cen, ben, rsv, val, q;
   logic [7:0] core;
   logic [6:0] vco;
   int n_mismatch = 0;
   int compares = 0;
   logic [5:0] tc [16] = '{6'h22, 6'h26, 6'h00, 6'h2e, 6'h3e, 6'h16, 6'h38, 6'h32, 6'h06, 6'h36, 6'h02, 6'h0a,
      6'h0e, 6'h12, 6'h1a, 6'h3a};
   logic [7:0] tm [16] = '{8'h2a, 8'h2c, 8'h2e, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48,
      8'h50, 8'h54, 8'h60, 8'h70};
   strap_board brd (.clk(MCLK), .code(code), .cfg(cfg), .qual(qual));
   pll_ratio_strap_decoder dut (.MCLK(MCLK), .RST(RST), .RATIO_CFG(cfg), .BYPASS_PHASE_QUALIFIER(qual),
      .DYNAMIC_FREQ_SWITCHING(dynamic_freq_switching), .CORE_MULT_X4(core), .VCO_MULT_X2(vco), .PLL_ENABLE(pen), .PLL_BYPASS(byp),
      .CORE_CLOCK_ENABLE(cen), .BUS_CLOCK_ENABLE(ben), .RESERVED_CODE(rsv), .CFG_VALID(val));
   initial forever #5 MCLK = ~MCLK;
   task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic look(logic [7:0] c, logic [6:0] v, logic [4:0] f);
      chk("core", core, c);
      chk("vco", {1'b0, vco}, {1'b0, v});
      chk("flags", {3'h0, pen, byp, cen, rsv, val}, {3'h0, f});
   endtask : look
   // boot changes the straps only while reset is held
   task automatic boot(logic [5:0] c);
      @(posedge MCLK);
      RST <= 1'b1;
      code <= c;
      repeat (5) @(posedge MCLK);
      RST <= 1'b0;
      repeat (6) @(posedge MCLK);
      #1;
   endtask : boot
   task automatic step(logic [1:0] d);
      @(posedge MCLK);
      dynamic_freq_switching <= d;
      repeat (2) @(posedge MCLK);
      #1;
   endtask : step
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   initial begin
      for (int i = 0; i < 16; i++) begin
         boot(tc[i]);
         look(tm[i], 7'h02, 5'h15);
      end
      step(2'h1);
      chk("half", core, 8'h38);
      step(2'h2);
      chk("quarter", core, 8'h1c);
      step(2'h0);
      chk("full", core, 8'h70);
      step(2'h3);
      chk("dfs3", core, 8'h70);
      boot(6'h0c);
      look(8'h04, 7'h00, 5'h0d);
      repeat (4) begin
         @(negedge MCLK);
         #1;
         q = qual;
         @(posedge MCLK);
         #1;
         chk("bus", {7'h0, ben}, {7'h0, q});
      end
      boot(6'h3c);
      look(8'h00, 7'h00, 5'h01);
      chk("offbus", {7'h0, ben}, 8'h00);
      // one reserved code on purpose, bit 0 high
      boot(6'h01);
      look(8'h00, 7'h00, 5'h03);
      boot(6'h0e);
      @(posedge MCLK);
      code <= 6'h3a;
      repeat (3) @(posedge MCLK);
      #1;
      look(8'h50, 7'h02, 5'h15);
      final_report();
   end
   initial begin
      #20000;
      n_mismatch++;
      final_report();
   end
endmodule : pll_ratio_strap_decoder_tb
`default_nettype wire
